/* File: hdl/asq_acq_seq.sv */
// What this block does
// - host writes a 4-bit input select into each of four ordered slots
// - host preloads counter with four minus inputs; third bit preloads all-converted
// - three-bit counter advances per conversion; top bit is all-converted
// - preload 0 gives four conversions, preload 3 gives exactly one
// - low counter bits index slot memory and result registers
// - sample trigger gated off for 1.6 ms after each sweep-dac write
// - rising sample trigger latches hold low
// - convert-start asserted 3.6 ms after hold
// - conversion complete raises result write and stores at the index
// - counter advances; convert-start reissued after another 3.6 ms
// - count of four raises all-converted and the acquisition interrupt
// - sweep-dac write resets settle timer, hold latch and counter
// - too-fast flag set when trigger rises within 3.2 ms of dac write
// - marker rising edge sets marker latch if capture enabled
// - bright marker rising edge sets its latch if capture enabled
// - marker clear strobe clears both marker latches
// - status read returns eight status lines
// - blank, unblank, marker, retrace events OR into status interrupt
// - each event sets the interrupt latch only when its enable is high
// - result read clears the acquisition interrupt latch
// - status read clears the status interrupt latch
// - summary flag ORs states and is stored only at the last index
// - result word is fifteen adc bits plus the summary flag
// - convert-start low starts a conversion; done shown by low
`include "asq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module asq_acq_seq
   import asq_pkg::*;
#(
   parameter int SETTLE_CYC = `ASQ_SETTLE_US * `ASQ_CLK_MHZ,
   parameter int S2C_CYC = `ASQ_S2C_US * `ASQ_CLK_MHZ,
   parameter int FAST_CYC = `ASQ_FAST_US * `ASQ_CLK_MHZ
) (
   input wire logic aclk, // block clock
   input wire logic aresetn, // sync reset, low active
   input wire logic ce, // clock enable
   input wire asq_wreq_t wreq, // axi write requests
   output asq_wrsp_t wrsp, // axi write answers
   input wire asq_rreq_t rreq, // axi read requests
   output asq_rrsp_t rrsp, // axi read answers
   input wire asq_pins_t pins_in, // comparator and adc pins
   input wire logic [14:0] adc_data, // adc result bits
   output logic [11:0] sweep_dac_data, // sweep dac value
   output logic sweep_dac_write_n, // dac write strobe
   output logic trigger_inhibit, // holds trigger inactive
   output logic hold_n, // sample/hold command
   output logic convert_n, // adc convert-start
   output logic result_write, // result store strobe
   output logic [3:0] mux_select, // input multiplexer select
   output logic all_converted, // series complete
   output logic acq_irq_n, // acquisition interrupt
   output logic status_irq_n, // status interrupt
   output logic summary_flag_n // summary status flag
);

   localparam logic [19:0] SETTLE_C = 20'(SETTLE_CYC);
   localparam logic [19:0] S2C_C = 20'(S2C_CYC);
   localparam logic [19:0] FAST_C = 20'(FAST_CYC);

   // write channel state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   // read channel state
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   // software registers
   logic [3:0] slot_mem [4];
   logic [2:0] preload;
   logic [4:0] irq_en;
   // acquisition state
   asq_state_t state;
   logic [2:0] count;
   logic [19:0] elapsed;
   logic [19:0] dly;
   logic too_fast;
   logic [15:0] result_mem [4];
   logic marker_latched;
   logic bright_marker_latched;
   logic acq_irq;
   logic status_irq;
   logic summary_flag;
   asq_pins_t pins_s;
   asq_pins_t pins_q;
   logic trig_gated_q;

   // pin synchroniser
   asq_sync #(
      .W($bits(asq_pins_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(pins_in),
      .q(pins_s)
   );

   // write decode
   wire do_write = aw_held && w_held && !bvalid;
   wire lane_lo = w_strb[0];
   wire lane_dac = &w_strb[1:0];
   wire w_slot = aw_addr[7:4] == 4'(`ASQ_OFS_SLOT >> 4);
   wire w_pre = aw_addr[7:2] == 6'(`ASQ_OFS_PRELOAD >> 2);
   wire w_dac = aw_addr[7:2] == 6'(`ASQ_OFS_DAC >> 2);
   wire w_ien = aw_addr[7:2] == 6'(`ASQ_OFS_IRQEN >> 2);
   wire w_mclr = aw_addr[7:2] == 6'(`ASQ_OFS_MKCLR >> 2);
   wire w_ok = w_slot | w_pre | w_dac | w_ien | w_mclr;
   wire dac_wr = do_write && w_dac && lane_dac;
   wire mkr_clr = do_write && w_mclr && lane_lo;
   wire dac_rst = !sweep_dac_write_n;

   // read decode
   wire ar_take = rreq.arvalid && !rvalid;
   wire [7:0] ra = rreq.araddr;
   wire r_stat = ra[7:2] == 6'(`ASQ_OFS_STATUS >> 2);
   wire r_res = ra[7:4] == 4'(`ASQ_OFS_RESULT >> 4);
   wire r_slot = ra[7:4] == 4'(`ASQ_OFS_SLOT >> 4);
   wire r_pre = ra[7:2] == 6'(`ASQ_OFS_PRELOAD >> 2);
   wire r_dac = ra[7:2] == 6'(`ASQ_OFS_DAC >> 2);
   wire r_ien = ra[7:2] == 6'(`ASQ_OFS_IRQEN >> 2);
   wire r_cnt = ra[7:2] == 6'(`ASQ_OFS_COUNT >> 2);
   wire r_mclr = ra[7:2] == 6'(`ASQ_OFS_MKCLR >> 2);
   wire r_ok = r_stat | r_res | r_slot | r_pre | r_dac | r_ien | r_cnt
      | r_mclr;
   wire status_rd = ar_take && r_stat;
   wire result_rd = ar_take && r_res;

   // eight status lines
   wire [7:0] status_word = {summary_flag, too_fast, all_converted,
      bright_marker_latched, marker_latched, pins_s.retrace_detect,
      pins_s.blank_detect, !hold_n};

   // read data selection
   wire [31:0] rd_mux = r_stat ? {24'h000000, status_word} :
      r_res ? {16'h0000, result_mem[ra[3:2]]} :
      r_slot ? {28'h0000000, slot_mem[ra[3:2]]} :
      r_pre ? {29'h00000000, preload} :
      r_dac ? {20'h00000, sweep_dac_data} :
      r_ien ? {27'h0000000, irq_en} :
      r_cnt ? {29'h00000000, count} : 32'h00000000;

   assign wrsp = '{awready: !aw_held, wready: !w_held, bvalid: bvalid,
      bresp: bresp};
   assign rrsp = '{arready: !rvalid, rvalid: rvalid, rdata: rdata,
      rresp: rresp};

   // sequencing terms
   wire [1:0] seq_index = count[1:0];
   wire settled = elapsed >= SETTLE_C;
   wire in_window = elapsed < FAST_C;
   wire trig_gated = pins_s.sample_trigger && settled;
   wire trig_rise = trig_gated && !trig_gated_q;
   wire done_fall = !pins_s.conv_done_n && pins_q.conv_done_n;
   wire [2:0] count_nx = 3'(count + 3'h1);
   wire last_index = seq_index == 2'h3;

   // edge events for markers and interrupts
   wire mkr_rise = pins_s.marker_comp && !pins_q.marker_comp;
   wire bri_rise = pins_s.bright_comp && !pins_q.bright_comp;
   wire blk_rise = pins_s.blank_detect && !pins_q.blank_detect;
   wire blk_fall = !pins_s.blank_detect && pins_q.blank_detect;
   wire rtr_rise = pins_s.retrace_detect && !pins_q.retrace_detect;
   wire mk_cap = irq_en[`ASQ_IEN_MKCAP];
   wire stat_evt = (blk_rise && irq_en[`ASQ_IEN_BLANK])
      | (blk_fall && irq_en[`ASQ_IEN_UNBLANK])
      | (mkr_rise && irq_en[`ASQ_IEN_MARKER])
      | (rtr_rise && irq_en[`ASQ_IEN_RETRACE]);
   wire acq_set = (state == ASQ_STORE) && count_nx[2];

   assign all_converted = count[2];
   assign trigger_inhibit = !settled;
   assign acq_irq_n = !acq_irq;
   assign status_irq_n = !status_irq;

   // axi write channels and register writes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `ASQ_RESP_OKAY;
         preload <= `ASQ_RST_PRELOAD;
         irq_en <= `ASQ_RST_IRQEN;
         sweep_dac_data <= `ASQ_RST_DAC;
         sweep_dac_write_n <= 1'b1;
      end
      else if (ce)
      begin
         if (wreq.awvalid && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= wreq.awaddr;
         end
         if (wreq.wvalid && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= wreq.wdata;
            w_strb <= wreq.wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= w_ok ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
         end
         else if (bvalid && wreq.bready)
            bvalid <= 1'b0;
         if (do_write && w_pre && lane_lo)
            preload <= w_data[2:0];
         if (do_write && w_ien && lane_lo)
            irq_en <= w_data[4:0];
         if (dac_wr)
            sweep_dac_data <= w_data[11:0];
         sweep_dac_write_n <= !dac_wr;
      end
   end

   // channel order memory, one flop row per slot
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         slot_mem <= '{default: 4'h0};
      else if (ce && do_write && w_slot && lane_lo)
         slot_mem[aw_addr[3:2]] <= w_data[3:0];
   end

   // axi read channels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `ASQ_RESP_OKAY;
      end
      else if (ce)
      begin
         if (ar_take)
         begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= r_ok ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
         end
         else if (rvalid && rreq.rready)
            rvalid <= 1'b0;
      end
   end

   // settle and too-fast timer since the last dac write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         elapsed <= 20'h00000;
      else if (ce)
      begin
         if (dac_rst)
            elapsed <= 20'h00000;
         else if (elapsed < FAST_C)
            elapsed <= 20'(elapsed + 20'h00001);
      end
   end

   // pin history for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pins_q <= '0;
         trig_gated_q <= 1'b0;
         mux_select <= 4'h0;
      end
      else if (ce)
      begin
         pins_q <= pins_s;
         trig_gated_q <= trig_gated;
         mux_select <= slot_mem[seq_index];
      end
   end

   // acquisition sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ASQ_IDLE;
         count <= `ASQ_RST_COUNT;
         dly <= 20'h00000;
         hold_n <= 1'b1;
         convert_n <= 1'b1;
         result_write <= 1'b0;
         too_fast <= 1'b0;
      end
      else if (ce)
      begin
         if (dac_rst)
         begin
            state <= ASQ_IDLE;
            count <= preload;
            hold_n <= 1'b1;
            convert_n <= 1'b1;
            result_write <= 1'b0;
            too_fast <= 1'b0;
         end
         else
         begin
            case (state)
               ASQ_IDLE:
               begin
                  if (trig_rise && !count[2])
                  begin
                     hold_n <= 1'b0;
                     too_fast <= in_window;
                     dly <= 20'h00000;
                     state <= ASQ_DELAY;
                  end
               end
               ASQ_DELAY:
               begin
                  dly <= 20'(dly + 20'h00001);
                  if (dly >= 20'(S2C_C - 20'h00001))
                  begin
                     convert_n <= 1'b0;
                     state <= ASQ_CONVERT;
                  end
               end
               ASQ_CONVERT:
               begin
                  if (done_fall)
                  begin
                     convert_n <= 1'b1;
                     result_write <= 1'b1;
                     state <= ASQ_STORE;
                  end
               end
               ASQ_STORE:
               begin
                  result_write <= 1'b0;
                  count <= count_nx;
                  dly <= 20'h00000;
                  state <= count_nx[2] ? ASQ_IDLE : ASQ_DELAY;
               end
               default:
                  state <= ASQ_IDLE;
            endcase
         end
      end
   end

   // result registers, written at the current index
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         result_mem <= '{default: 16'h0000};
      else if (ce && state == ASQ_CONVERT && done_fall && !dac_rst)
         result_mem[seq_index] <=
            {summary_flag && last_index, adc_data};
   end

   // marker latches, set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         marker_latched <= 1'b0;
         bright_marker_latched <= 1'b0;
      end
      else if (ce)
      begin
         marker_latched <= (mkr_rise && mk_cap)
            || (marker_latched && !mkr_clr);
         bright_marker_latched <= (bri_rise && mk_cap)
            || (bright_marker_latched && !mkr_clr);
      end
   end

   // interrupt latches and summary flag, set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acq_irq <= 1'b0;
         status_irq <= 1'b0;
         summary_flag <= 1'b0;
         summary_flag_n <= 1'b1;
      end
      else if (ce)
      begin
         acq_irq <= acq_set || (acq_irq && !result_rd);
         status_irq <= stat_evt || (status_irq && !status_rd);
         summary_flag <= marker_latched || pins_s.blank_detect
            || pins_s.retrace_detect || too_fast;
         summary_flag_n <= !(summary_flag && last_index);
      end
   end

endmodule : asq_acq_seq

`default_nettype wire

/* File: hdl/asq_cfg.svh */
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH

// block clock rate
`define ASQ_CLK_MHZ 250
// settling after a sweep-dac write, 1.6 ms
`define ASQ_SETTLE_US 1600
// hold to convert-start delay, 3.6 ms
`define ASQ_S2C_US 3600
// sweep-too-fast window, 3.2 ms
`define ASQ_FAST_US 3200

// register byte offsets
`define ASQ_OFS_SLOT 8'h00
`define ASQ_OFS_PRELOAD 8'h10
`define ASQ_OFS_DAC 8'h14
`define ASQ_OFS_IRQEN 8'h18
`define ASQ_OFS_STATUS 8'h1c
`define ASQ_OFS_MKCLR 8'h20
`define ASQ_OFS_COUNT 8'h24
`define ASQ_OFS_RESULT 8'h40

// irq enable field positions
`define ASQ_IEN_BLANK 0
`define ASQ_IEN_UNBLANK 1
`define ASQ_IEN_MARKER 2
`define ASQ_IEN_RETRACE 3
`define ASQ_IEN_MKCAP 4

// reset values
`define ASQ_RST_PRELOAD 3'h0
`define ASQ_RST_IRQEN 5'h00
`define ASQ_RST_DAC 12'h000
`define ASQ_RST_COUNT 3'h4

// axi responses
`define ASQ_RESP_OKAY 2'h0
`define ASQ_RESP_SLVERR 2'h2

`endif

/* File: hdl/asq_pkg.sv */
package asq_pkg;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
   } asq_wreq_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
   } asq_wrsp_t;

   typedef struct packed {
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } asq_rreq_t;

   typedef struct packed {
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } asq_rrsp_t;

   // comparator and adc pins, all asynchronous
   typedef struct packed {
      logic sample_trigger;
      logic conv_done_n;
      logic marker_comp;
      logic bright_comp;
      logic blank_detect;
      logic retrace_detect;
   } asq_pins_t;

   typedef enum logic [1:0] {
      ASQ_IDLE,
      ASQ_DELAY,
      ASQ_CONVERT,
      ASQ_STORE
   } asq_state_t;

endpackage : asq_pkg

/* File: hdl/asq_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module asq_sync #(
   parameter int W = 6
) (
   input wire logic aclk, // block clock
   input wire logic aresetn, // sync reset, low active
   input wire logic ce, // clock enable
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // filtered, synchronous
);

   genvar i;
   // three shift flops and an output flop per bit, accept once second and third agree
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               q[i] <= 1'b0;
            end
            else if (ce)
            begin
               s1 <= d[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  q[i] <= s3;
            end
         end
      end
   endgenerate

endmodule : asq_sync

`default_nettype wire

/* File: testbench/asq_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none

module asq_adc_model #(
   parameter int CONV_CYC = 10
) (
   input wire logic aclk, // block clock
   input wire logic convert_n, // convert-start, low
   input wire logic [3:0] mux_select, // selected input
   output logic conv_done_n, // completion, low
   output logic [14:0] adc_data // result bits
);
   int busy;

   initial
   begin
      busy = 0;
      conv_done_n = 1'b1;
      adc_data = 15'h0;
   end

   // one conversion per low convert-start, data valid only while done
   always @(posedge aclk)
   begin
      if (convert_n || busy < CONV_CYC)
         adc_data <= ~adc_data; // released lines toggle
      else
         adc_data <= {11'h2a5, mux_select};
      conv_done_n <= convert_n || busy < CONV_CYC;
      busy <= convert_n ? 0 : busy + 1;
   end
endmodule : asq_adc_model

`default_nettype wire

/* File: testbench/asq_acq_seq_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module asq_acq_seq_chk
   import asq_pkg::*;
#(
   parameter int S2C_CYC = 40
) (
   input wire logic aclk, // block clock
   input wire logic aresetn, // sync reset, low
   input wire logic ce, // clock enable
   input wire asq_rreq_t rreq, // read requests
   input wire asq_rrsp_t rrsp, // read answers
   input wire logic sweep_dac_write_n, // dac strobe
   input wire logic trigger_inhibit, // trigger gate
   input wire logic hold_n, // hold command
   input wire logic convert_n, // convert-start
   input wire logic result_write, // store strobe
   input wire logic all_converted, // series done
   input wire logic acq_irq_n, // acquisition irq
   input wire logic status_irq_n // status irq
);
   localparam int GAP_LO = S2C_CYC - 2;
   localparam int GAP_HI = S2C_CYC + 2;
   int gap;
   logic ar_take;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !ce);

   // read address handshake
   assign ar_take = rreq.arvalid && rrsp.arready;

   // cycles spent held while waiting for convert-start
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_n || !convert_n)
         gap <= 0;
      else if (ce)
         gap <= gap + 1;
   end

   chk_dac_pulse: assert property (
      $fell(sweep_dac_write_n) |=> sweep_dac_write_n)
      else $error("dac strobe longer than one cycle");
   chk_settle_gate: assert property (
      !sweep_dac_write_n |=> trigger_inhibit [*8])
      else $error("trigger not gated after dac write");
   chk_dac_reset: assert property (
      !sweep_dac_write_n |-> ##[0:1] (hold_n && !all_converted))
      else $error("dac write left hold or count");
   chk_hold_cause: assert property (
      $fell(hold_n) |-> !trigger_inhibit && !all_converted)
      else $error("hold taken while gated or done");
   chk_conv_delay: assert property (
      $fell(convert_n) |-> gap >= GAP_LO && gap <= GAP_HI)
      else $error("convert-start delay wrong");
   chk_conv_late: assert property (
      !hold_n && convert_n && !all_converted |-> gap <= GAP_HI)
      else $error("convert-start not reissued");
   chk_store_pulse: assert property (
      result_write |-> convert_n && !$past(convert_n) ##1 !result_write)
      else $error("store strobe not tied to done");
   chk_done_irq: assert property (
      $rose(all_converted) |-> !acq_irq_n)
      else $error("no irq at series end");
   chk_result_clr: assert property (
      ar_take && rreq.araddr[7:4] == 4'h4 |-> ##[1:2] acq_irq_n)
      else $error("result read kept irq");
   chk_status_clr: assert property (
      ar_take && rreq.araddr == 8'h1c |-> ##[1:2] status_irq_n)
      else $error("status read kept irq");
endmodule : asq_acq_seq_chk

bind asq_acq_seq asq_acq_seq_chk #(
   .S2C_CYC(S2C_CYC)
) chk_u (
   .aclk, .aresetn, .ce, .rreq, .rrsp, .sweep_dac_write_n,
   .trigger_inhibit, .hold_n, .convert_n, .result_write,
   .all_converted, .acq_irq_n, .status_irq_n
);

`default_nettype wire

/* File: testbench/asq_acq_seq_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module asq_acq_seq_tb
   import asq_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn, trig, mk, br, bl, rt, conv_done_n;
   logic sweep_dac_write_n, trigger_inhibit, hold_n, convert_n;
   logic result_write, all_converted, acq_irq_n, status_irq_n;
   logic summary_flag_n;
   logic [14:0] adc_data;
   logic [3:0] mux_select;
   logic [11:0] sweep_dac_data;
   logic [31:0] rd;
   logic [3:0] ch [4] = '{4'h3, 4'ha, 4'h5, 4'hc};
   asq_wreq_t wreq;
   asq_wrsp_t wrsp;
   asq_rreq_t rreq;
   asq_rrsp_t rrsp;
   asq_pins_t pins;
   int miscompares, compares, nwr;

   // pins in struct order
   assign pins = {trig, conv_done_n, mk, br, bl, rt};

   initial
   begin
      forever #2 aclk = ~aclk;
   end

   asq_acq_seq #(
      .SETTLE_CYC(20),
      .S2C_CYC(40),
      .FAST_CYC(30)
   ) dut_u (
      .aclk, .aresetn, .ce(1'b1), .wreq, .wrsp, .rreq, .rrsp,
      .pins_in(pins), .adc_data, .sweep_dac_data, .sweep_dac_write_n,
      .trigger_inhibit, .hold_n, .convert_n, .result_write, .mux_select,
      .all_converted, .acq_irq_n, .status_irq_n, .summary_flag_n
   );

   asq_adc_model #(
      .CONV_CYC(10)
   ) adc_u (
      .aclk, .convert_n, .mux_select, .conv_done_n, .adc_data
   );

   // count store strobes
   always @(posedge aclk)
   begin
      if (result_write === 1'b1)
         nwr++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s %h %h", $time, what, got, exp);
      end
   endtask : check

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge aclk);
      wreq <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1};
      do
      begin
         @(posedge aclk);
         if (wreq.awvalid && wrsp.awready)
            wreq.awvalid <= 1'b0;
         if (wreq.wvalid && wrsp.wready)
            wreq.wvalid <= 1'b0;
      end
      while (wrsp.bvalid !== 1'b1);
      wreq.bready <= 1'b0;
      check(32'(wrsp.bresp), 32'(er), "bresp");
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge aclk);
      rreq <= '{1'b1, a, 1'b1};
      do
      begin
         @(posedge aclk);
         if (rreq.arvalid && rrsp.arready)
            rreq.arvalid <= 1'b0;
      end
      while (rrsp.rvalid !== 1'b1);
      rreq.rready <= 1'b0;
      rd = rrsp.rdata;
      check(32'(rrsp.rresp), 32'(er), "rresp");
   endtask : axi_rd

   task automatic t_reset;
      logic [7:0] lv;
      lv = {all_converted, hold_n, convert_n, acq_irq_n, status_irq_n,
         sweep_dac_write_n, trigger_inhibit, summary_flag_n};
      check(32'(lv), 32'hff, "reset levels");
      axi_rd(8'h24, 2'h0);
      check(rd, 32'h4, "count");
      axi_wr(8'h30, 32'h0, 2'h2);
      axi_rd(8'h30, 2'h2);
   endtask : t_reset

   task automatic t_acq(input int n);
      logic f;
      for (int i = 0; i < 4; i++)
         axi_wr(8'(4 * i), {28'h0, ch[i]}, 2'h0);
      axi_wr(8'h10, 32'(4 - n), 2'h0);
      rt <= (n == 1 || n == 4);
      axi_wr(8'h14, 32'h800 + n, 2'h0);
      repeat (2) @(posedge aclk);
      check(32'(all_converted), 32'h0, "count reload");
      check(32'(sweep_dac_data), 32'h800 + n, "dac value");
      while (trigger_inhibit !== 1'b0)
         @(posedge aclk);
      repeat (20) @(posedge aclk);
      nwr = 0;
      trig <= 1'b1;
      repeat (8) @(posedge aclk);
      check(32'(hold_n), 32'h0, "hold");
      check(32'(summary_flag_n), 32'(n != 1), "summary flag");
      while (all_converted !== 1'b1)
         @(posedge aclk);
      repeat (2) @(posedge aclk);
      check(32'(nwr), 32'(n), "stores");
      check(32'(acq_irq_n), 32'h0, "done irq");
      trig <= 1'b0;
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[6:5]), 32'h1, "status");
      for (int i = 4 - n; i < 4; i++)
      begin
         axi_rd(8'(8'h40 + 4 * i), 2'h0);
         f = (i == 3) && rt;
         check(rd, {16'h0, f, 11'h2a5, ch[i]}, "result");
      end
      check(32'(acq_irq_n), 32'h1, "irq cleared");
      rt <= 1'b0;
   endtask : t_acq

   task automatic t_fast;
      axi_wr(8'h10, 32'h0, 2'h0);
      axi_wr(8'h14, 32'h123, 2'h0);
      trig <= 1'b1;
      repeat (10) @(posedge aclk);
      check(32'(hold_n), 32'h1, "gated trigger");
      while (hold_n !== 1'b0)
         @(posedge aclk);
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[6]), 32'h1, "too fast");
      trig <= 1'b0;
      axi_wr(8'h14, 32'h124, 2'h0);
      repeat (2) @(posedge aclk);
      check(32'(hold_n), 32'h1, "hold reset");
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[6]), 32'h0, "too fast reset");
   endtask : t_fast

   task automatic t_mark;
      logic [3:0] en [3] = '{4'h1, 4'h2, 4'h8};
      logic [1:0] st [3] = '{2'h1, 2'h0, 2'h2};
      mk <= 1'b1;
      repeat (8) @(posedge aclk);
      mk <= 1'b0;
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[4:3]), 32'h0, "marker ignored");
      axi_wr(8'h18, 32'h14, 2'h0);
      mk <= 1'b1;
      br <= 1'b1;
      repeat (8) @(posedge aclk);
      check(32'(status_irq_n), 32'h0, "marker irq");
      mk <= 1'b0;
      br <= 1'b0;
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[4:3]), 32'h3, "markers set");
      check(32'(status_irq_n), 32'h1, "status irq cleared");
      axi_wr(8'h20, 32'h0, 2'h0);
      axi_rd(8'h1c, 2'h0);
      check(32'(rd[4:3]), 32'h0, "markers cleared");
      bl <= 1'b1;
      repeat (8) @(posedge aclk);
      check(32'(status_irq_n), 32'h1, "masked event");
      bl <= 1'b0;
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 3; i++)
      begin
         axi_wr(8'h18, 32'(en[i]), 2'h0);
         bl <= (i == 0);
         rt <= (i == 2);
         repeat (8) @(posedge aclk);
         check(32'(status_irq_n), 32'h0, "event irq");
         axi_rd(8'h1c, 2'h0);
         check(32'(rd[2:1]), 32'(st[i]), "status lines");
         check(32'(status_irq_n), 32'h1, "irq cleared");
      end
   endtask : t_mark

   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // main sequence
   initial
   begin
      aresetn = 1'b0;
      {trig, mk, br, bl, rt} = 5'h0;
      wreq = '0;
      rreq = '0;
      miscompares = 0;
      compares = 0;
      nwr = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      for (int n = 1; n <= 4; n++)
         t_acq(n);
      t_fast;
      t_mark;
      finish_test;
   end

   // hang guard
   initial
   begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test;
   end
endmodule : asq_acq_seq_tb

`default_nettype wire
